// [hw/lrs_selector.sv]
// per-peer transmission scheme selection and keep-alive robustness control
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module lrs_selector #(
	parameter int NUM_PEERS     = 8,
	parameter int AGE_W         = 8,
	parameter int KA_MAX_RETRY  = 3,
	parameter int TICKS_PER_SEC = lrs_pkg::TICKS_PER_SEC
) (
	// clock and reset
	input  wire logic                         mclk,
	input  wire logic                         srst,
	// register port
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [31:0]                  reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [31:0]                  reg_rdata,
	// registration
	input  wire logic                         registration_done,
	// received packet report
	input  wire logic                         rx_pkt_valid,
	input  wire logic                         rx_pkt_generic,
	input  wire logic [$clog2(NUM_PEERS)-1:0] rx_peer_id,
	input  wire logic [3:0]                   rx_capability_field,
	// received keep-alive report
	input  wire logic                         rx_ka_valid,
	input  wire logic                         rx_ka_is_request,
	input  wire logic [3:0]                   rx_ka_tx_sequence,
	input  wire logic [7:0]                   rx_ka_snr,
	input  wire logic [7:0]                   rx_ka_power,
	input  wire logic [3:0]                   rx_ka_encoding,
	// transmit scheme query
	input  wire logic                         tx_req,
	input  wire logic [$clog2(NUM_PEERS)-1:0] tx_peer_id,
	input  wire logic                         tx_is_data,
	input  wire logic                         tx_frame_b,
	output logic                              tx_ans_valid,
	output logic      [3:0]                   tx_scheme,
	output logic      [3:0]                   tx_capability_field,
	// keep-alive transmit control
	input  wire logic                         ka_start,
	input  wire logic [$clog2(NUM_PEERS)-1:0] ka_peer_id,
	input  wire logic                         ka_ack,
	input  wire logic                         ka_no_ack,
	input  wire logic                         relax_req,
	output logic                              ka_send,
	output logic                              ka_is_response,
	output logic      [3:0]                   ka_scheme,
	output logic      [3:0]                   keepalive_tx_sequence,
	output logic      [3:0]                   tx_power,
	output logic                              ka_failed,
	output logic      [3:0]                   ka_ack_scheme,
	output logic      [7:0]                   last_rx_snr_field,
	output logic      [7:0]                   last_rx_power_field,
	output logic      [3:0]                   last_rx_encoding_field
);
	localparam int PW = $clog2(NUM_PEERS);

	generate
		if (NUM_PEERS < 2 || AGE_W < 1 || AGE_W > 16 || KA_MAX_RETRY < 1 ||
			KA_MAX_RETRY > 15) begin : g_bad
			$error("lrs_selector: unsupported parameter value");
		end
	endgenerate

	typedef enum logic [2:0] {
		KA_IDLE = 3'b001,
		KA_SEND = 3'b010,
		KA_WAIT = 3'b100
	} lrs_ka_type;

	// next step up the keep-alive ladder; saturates at robust DBPSK
	function automatic logic [3:0] ka_harder(input logic [3:0] s);
		case (s)
			lrs_pkg::SCH_DBPSK_CC:     ka_harder = lrs_pkg::SCH_ROBUST_DQPSK;
			default:                   ka_harder = lrs_pkg::SCH_ROBUST_DBPSK;
		endcase
	endfunction

	function automatic logic [3:0] ka_easier(input logic [3:0] s);
		case (s)
			lrs_pkg::SCH_ROBUST_DBPSK: ka_easier = lrs_pkg::SCH_ROBUST_DQPSK;
			default:                   ka_easier = lrs_pkg::SCH_DBPSK_CC;
		endcase
	endfunction

	logic sec_tick;

	lrs_tick_div #(
		.PERIOD (TICKS_PER_SEC)
	) u_tick (
		.mclk (mclk),
		.srst (srst),
		.tick (sec_tick)
	);

	// ---- configuration registers
	logic             adapt_stage_reg, adapt_stage_next;
	logic [3:0]       fixed_stage_reg, fixed_stage_next;
	logic             adapt_act_reg,   adapt_act_next;
	logic [3:0]       fixed_act_reg,   fixed_act_next;
	logic             locked_reg,      locked_next;
	logic             svc_node_reg,    svc_node_next;
	logic [3:0]       ctl_sch_reg,     ctl_sch_next;
	logic [AGE_W-1:0] timeout_reg,     timeout_next;
	logic [3:0]       local_cap_reg,   local_cap_next;
	logic [3:0]       pow_max_reg,     pow_max_next;
	logic [PW-1:0]    peer_sel_reg,    peer_sel_next;

	always_comb begin
		adapt_stage_next = adapt_stage_reg;
		fixed_stage_next = fixed_stage_reg;
		adapt_act_next   = adapt_act_reg;
		fixed_act_next   = fixed_act_reg;
		locked_next      = locked_reg;
		svc_node_next    = svc_node_reg;
		ctl_sch_next     = ctl_sch_reg;
		timeout_next     = timeout_reg;
		local_cap_next   = local_cap_reg;
		pow_max_next     = pow_max_reg;
		peer_sel_next    = peer_sel_reg;
		if (reg_wr) begin
			case (reg_addr)
				lrs_pkg::OFS_CTRL: begin
					adapt_stage_next = reg_wdata[lrs_pkg::CTRL_ADAPT_BIT];
					fixed_stage_next = reg_wdata[lrs_pkg::CTRL_FIXED_LSB +: 4];
					svc_node_next    = reg_wdata[lrs_pkg::CTRL_SVC_BIT];
					ctl_sch_next     = reg_wdata[lrs_pkg::CTRL_CTLSCH_LSB +: 4];
				end
				lrs_pkg::OFS_TIMEOUT:   timeout_next   = reg_wdata[AGE_W-1:0];
				lrs_pkg::OFS_LOCAL_CAP: local_cap_next = reg_wdata[3:0];
				lrs_pkg::OFS_POWER:     pow_max_next   = reg_wdata[3:0];
				lrs_pkg::OFS_PEER_SEL:  peer_sel_next  = reg_wdata[PW-1:0];
				default: ;
			endcase
		end
		// fixed mode is taken once at registration and then frozen
		if (registration_done && !locked_reg) begin
			adapt_act_next = adapt_stage_reg;
			fixed_act_next = fixed_stage_reg;
			locked_next    = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			adapt_stage_reg <= 1'b1;
			fixed_stage_reg <= lrs_pkg::SCH_ROBUST_DBPSK;
			adapt_act_reg   <= 1'b1;
			fixed_act_reg   <= lrs_pkg::SCH_ROBUST_DBPSK;
			locked_reg      <= 1'b0;
			svc_node_reg    <= 1'b0;
			ctl_sch_reg     <= lrs_pkg::CTLSCH_RST;
			timeout_reg     <= AGE_W'(lrs_pkg::TIMEOUT_RST);
			local_cap_reg   <= lrs_pkg::LOCAL_CAP_RST;
			pow_max_reg     <= lrs_pkg::POWER_MAX_RST;
			peer_sel_reg    <= '0;
		end else begin
			adapt_stage_reg <= adapt_stage_next;
			fixed_stage_reg <= fixed_stage_next;
			adapt_act_reg   <= adapt_act_next;
			fixed_act_reg   <= fixed_act_next;
			locked_reg      <= locked_next;
			svc_node_reg    <= svc_node_next;
			ctl_sch_reg     <= ctl_sch_next;
			timeout_reg     <= timeout_next;
			local_cap_reg   <= local_cap_next;
			pow_max_reg     <= pow_max_next;
			peer_sel_reg    <= peer_sel_next;
		end
	end

	// ---- keep-alive sequencer
	lrs_ka_type ka_st_reg,   ka_st_next;
	logic [3:0] rty_reg,     rty_next;
	logic [3:0] ladder_reg,  ladder_next;
	logic [3:0] pow_reg,     pow_next;
	logic [PW-1:0] ka_peer_reg, ka_peer_next;
	logic       resp_reg,    resp_next;
	logic       pend_resp_reg, pend_resp_next;
	logic       fail_next;
	logic       store_robust;

	always_comb begin
		ka_st_next     = ka_st_reg;
		rty_next       = rty_reg;
		ladder_next    = ladder_reg;
		pow_next       = pow_reg;
		ka_peer_next   = ka_peer_reg;
		resp_next      = resp_reg;
		pend_resp_next = pend_resp_reg;
		fail_next      = 1'b0;
		store_robust   = 1'b0;
		// a request heard by a service node queues its own response
		if (rx_ka_valid && rx_ka_is_request && svc_node_reg) begin
			pend_resp_next = 1'b1;
			ka_peer_next   = rx_peer_id;
		end
		case (ka_st_reg)
			KA_IDLE: begin
				if (ka_start || pend_resp_reg) begin
					ka_st_next     = KA_SEND;
					rty_next       = '0;
					resp_next      = pend_resp_reg && !ka_start;
					// a request heard in this very cycle stays queued
					pend_resp_next = (ka_start && pend_resp_reg) ||
						(rx_ka_valid && rx_ka_is_request && svc_node_reg);
					if (ka_start)
						ka_peer_next = ka_peer_id;
				end
			end
			KA_SEND: ka_st_next = KA_WAIT;
			KA_WAIT: begin
				if (ka_ack) begin
					ka_st_next = KA_IDLE;
				end else if (ka_no_ack) begin
					if (rty_reg == 4'(KA_MAX_RETRY)) begin
						ka_st_next   = KA_IDLE;
						fail_next    = 1'b1;
						store_robust = 1'b1;
					end else begin
						ka_st_next = KA_SEND;
						rty_next   = rty_reg + 4'h1;
						// first retry keeps robustness, later ones raise it
						if (rty_reg != 4'h0) begin
							if (pow_reg < pow_max_reg)
								pow_next = pow_reg + 4'h1;
							else
								ladder_next = ka_harder(ladder_reg);
						end
					end
				end
			end
			default: ka_st_next = KA_IDLE;
		endcase
		// relaxing goes modulation first, power only at the fastest step
		if (relax_req && ka_st_reg == KA_IDLE) begin
			if (ladder_reg != lrs_pkg::SCH_DBPSK_CC)
				ladder_next = ka_easier(ladder_reg);
			else if (pow_reg != 4'h0)
				pow_next = pow_reg - 4'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ka_st_reg     <= KA_IDLE;
			rty_reg       <= '0;
			ladder_reg    <= lrs_pkg::SCH_DBPSK_CC;
			pow_reg       <= '0;
			ka_peer_reg   <= '0;
			resp_reg      <= 1'b0;
			pend_resp_reg <= 1'b0;
			ka_failed     <= 1'b0;
		end else begin
			ka_st_reg     <= ka_st_next;
			rty_reg       <= rty_next;
			ladder_reg    <= ladder_next;
			pow_reg       <= pow_next;
			ka_peer_reg   <= ka_peer_next;
			resp_reg      <= resp_next;
			pend_resp_reg <= pend_resp_next;
			ka_failed     <= fail_next;
		end
	end

	assign ka_send               = (ka_st_reg == KA_SEND);
	assign ka_is_response        = resp_reg;
	assign ka_scheme             = ladder_reg;
	assign keepalive_tx_sequence = rty_reg;
	assign tx_power              = pow_reg;

	// ---- peer table, one entry per peer
	logic [AGE_W-1:0] age_reg  [NUM_PEERS];
	logic [AGE_W-1:0] age_next [NUM_PEERS];
	logic [3:0]       sch_reg  [NUM_PEERS];
	logic [3:0]       sch_next [NUM_PEERS];
	logic             seen_reg [NUM_PEERS];
	logic             seen_next[NUM_PEERS];

	genvar g;
	generate
		for (g = 0; g < NUM_PEERS; g++) begin : g_peer
			always_comb begin
				age_next[g]  = age_reg[g];
				sch_next[g]  = sch_reg[g];
				seen_next[g] = seen_reg[g];
				if (sec_tick && age_reg[g] != {AGE_W{1'b1}})
					age_next[g] = age_reg[g] + AGE_W'(1);
				if (store_robust && ka_peer_reg == PW'(g)) begin
					sch_next[g]  = lrs_pkg::MOST_ROBUST_B;
					age_next[g]  = '0;
					seen_next[g] = 1'b1;
				end
				// a fresh report from the peer outranks the tick and a failed link
				if (rx_pkt_valid && rx_pkt_generic && rx_peer_id == PW'(g)) begin
					sch_next[g]  = rx_capability_field;
					age_next[g]  = '0;
					seen_next[g] = 1'b1;
				end
			end

			always_ff @(posedge mclk) begin
				if (srst) begin
					age_reg[g]  <= '0;
					sch_reg[g]  <= lrs_pkg::SCH_UNKNOWN;
					seen_reg[g] <= 1'b0;
				end else begin
					age_reg[g]  <= age_next[g];
					sch_reg[g]  <= sch_next[g];
					seen_reg[g] <= seen_next[g];
				end
			end
		end
	endgenerate

	// ---- transmit scheme answer, one cycle after the query
	logic [3:0] sch_pick;
	logic [3:0] robust_pick;
	logic       stale;

	always_comb begin
		robust_pick = tx_frame_b ? lrs_pkg::MOST_ROBUST_B : lrs_pkg::MOST_ROBUST_A;
		stale = !seen_reg[tx_peer_id] || (age_reg[tx_peer_id] >= timeout_reg);
		if (!tx_is_data)
			sch_pick = ctl_sch_reg;
		else if (locked_reg && !adapt_act_reg)
			sch_pick = fixed_act_reg;
		else if (stale)
			sch_pick = robust_pick;
		else if (sch_reg[tx_peer_id] == lrs_pkg::SCH_UNKNOWN ||
			sch_reg[tx_peer_id] > lrs_pkg::SCH_LAST_VALID)
			sch_pick = robust_pick;
		else
			sch_pick = sch_reg[tx_peer_id];
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_ans_valid        <= 1'b0;
			tx_scheme           <= lrs_pkg::SCH_ROBUST_DBPSK;
			tx_capability_field <= lrs_pkg::LOCAL_CAP_RST;
		end else begin
			tx_ans_valid        <= tx_req;
			if (tx_req)
				tx_scheme <= sch_pick;
			tx_capability_field <= local_cap_reg;
		end
	end

	// ---- last received keep-alive and acknowledgement robustness
	logic [3:0] ack_next;

	always_comb begin
		ack_next = ka_ack_scheme;
		if (rx_ka_valid) begin
			ack_next = ctl_sch_reg;
			// a copy sent more than twice: never answer less robustly
			if (rx_ka_tx_sequence > 4'h1 && rx_ka_encoding < ctl_sch_reg)
				ack_next = rx_ka_encoding;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ka_ack_scheme          <= lrs_pkg::CTLSCH_RST;
			last_rx_snr_field      <= '0;
			last_rx_power_field    <= '0;
			last_rx_encoding_field <= '0;
		end else begin
			ka_ack_scheme <= ack_next;
			if (rx_ka_valid) begin
				last_rx_snr_field      <= rx_ka_snr;
				last_rx_power_field    <= rx_ka_power;
				last_rx_encoding_field <= rx_ka_encoding;
			end
		end
	end

	// ---- register read, data in the cycle after the strobe
	logic [31:0] rd_next;

	always_comb begin
		rd_next = '0;
		if (reg_rd) begin
			case (reg_addr)
				lrs_pkg::OFS_CTRL: begin
					rd_next[lrs_pkg::CTRL_ADAPT_BIT]        = adapt_stage_reg;
					rd_next[lrs_pkg::CTRL_SVC_BIT]          = svc_node_reg;
					rd_next[lrs_pkg::CTRL_FIXED_LSB +: 4]   = fixed_stage_reg;
					rd_next[lrs_pkg::CTRL_CTLSCH_LSB +: 4]  = ctl_sch_reg;
				end
				lrs_pkg::OFS_TIMEOUT:   rd_next[AGE_W-1:0] = timeout_reg;
				lrs_pkg::OFS_LOCAL_CAP: rd_next[3:0]       = local_cap_reg;
				lrs_pkg::OFS_POWER: begin
					rd_next[3:0]                          = pow_max_reg;
					rd_next[lrs_pkg::POWER_CUR_LSB +: 4]  = pow_reg;
				end
				lrs_pkg::OFS_STATUS: begin
					rd_next[lrs_pkg::STATUS_LOCK_BIT]     = locked_reg;
					rd_next[lrs_pkg::STATUS_KA_LSB +: 3]  = ka_st_reg;
					rd_next[lrs_pkg::STATUS_RTY_LSB +: 4] = rty_reg;
				end
				lrs_pkg::OFS_PEER_SEL: begin
					rd_next[3:0]                               = sch_reg[peer_sel_reg];
					rd_next[lrs_pkg::PEER_AGE_LSB +: AGE_W]    = age_reg[peer_sel_reg];
					rd_next[lrs_pkg::PEER_SEEN_BIT]            = seen_reg[peer_sel_reg];
				end
				lrs_pkg::OFS_LAST_KA: begin
					rd_next[7:0]                         = last_rx_snr_field;
					rd_next[lrs_pkg::LKA_POW_LSB +: 8]   = last_rx_power_field;
					rd_next[lrs_pkg::LKA_ENC_LSB +: 4]   = last_rx_encoding_field;
				end
				default: rd_next = '0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst)
			reg_rdata <= '0;
		else
			reg_rdata <= rd_next;
	end
endmodule // lrs_selector

// [hw/lrs_pkg.sv]
// shared constants for the link robustness selector
package lrs_pkg;
	// transmission schemes, lower code means more robust
	localparam logic [3:0] SCH_ROBUST_DBPSK = 4'h0;
	localparam logic [3:0] SCH_ROBUST_DQPSK = 4'h1;
	localparam logic [3:0] SCH_DBPSK_CC     = 4'h2;
	localparam logic [3:0] SCH_DBPSK        = 4'h3;
	localparam logic [3:0] SCH_DQPSK_CC     = 4'h4;
	localparam logic [3:0] SCH_DQPSK        = 4'h5;
	localparam logic [3:0] SCH_D8PSK_CC     = 4'h6;
	localparam logic [3:0] SCH_D8PSK        = 4'h7;
	localparam logic [3:0] SCH_UNKNOWN      = 4'hf;
	localparam logic [3:0] SCH_LAST_VALID   = 4'h7;
	// most robust scheme per frame type (type a has no robust modes)
	localparam logic [3:0] MOST_ROBUST_A    = SCH_DBPSK_CC;
	localparam logic [3:0] MOST_ROBUST_B    = SCH_ROBUST_DBPSK;

	// register word offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_TIMEOUT   = 8'h04;
	localparam logic [7:0] OFS_LOCAL_CAP = 8'h08;
	localparam logic [7:0] OFS_POWER     = 8'h0c;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_PEER_SEL  = 8'h14;
	localparam logic [7:0] OFS_LAST_KA   = 8'h18;

	// field positions
	localparam int CTRL_ADAPT_BIT  = 0;
	localparam int CTRL_SVC_BIT    = 1;
	localparam int CTRL_FIXED_LSB  = 4;
	localparam int CTRL_CTLSCH_LSB = 8;
	localparam int POWER_CUR_LSB   = 8;
	localparam int STATUS_LOCK_BIT = 0;
	localparam int STATUS_KA_LSB   = 4;
	localparam int STATUS_RTY_LSB  = 8;
	localparam int PEER_AGE_LSB    = 4;
	localparam int PEER_SEEN_BIT   = 31;
	localparam int LKA_POW_LSB     = 8;
	localparam int LKA_ENC_LSB     = 16;

	// reset values
	localparam logic [7:0] TIMEOUT_RST   = 8'h3c;
	localparam logic [3:0] LOCAL_CAP_RST = SCH_UNKNOWN;
	localparam logic [3:0] POWER_MAX_RST = 4'h7;
	localparam logic [3:0] CTLSCH_RST    = SCH_DBPSK_CC;

	// timing: one second at the 5 ns clock
	localparam int CLK_PERIOD_NS = 5;
	localparam int SECOND_NS     = 1000000000;
	localparam int TICKS_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
endpackage

// [hw/lrs_tick_div.sv]
// one-cycle enable pulse every PERIOD clock cycles
`timescale 1ns/100ps
module lrs_tick_div #(
	parameter int PERIOD = 200000000
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic srst,
	// enable out
	output logic      tick
);
	localparam int CW = $clog2(PERIOD);

	generate
		if (PERIOD < 2) begin : g_bad
			$error("lrs_tick_div: PERIOD must be at least 2");
		end
	endgenerate

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic          tick_next;

	always_comb begin
		tick_next = 1'b0;
		cnt_next  = cnt_reg + CW'(1);
		if (cnt_reg == CW'(PERIOD - 1)) begin
			cnt_next  = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick    <= tick_next;
		end
	end
endmodule // lrs_tick_div

// [testbench/lrs_selector_assertions.sv]
// concurrent checks on the scheme selector ports
`timescale 1ns/100ps
module lrs_sel_chk #(
	parameter int KA_MAX_RETRY = 3
) (
	// clock and reset
	input wire logic        mclk,
	input wire logic        srst,
	// watched inputs
	input wire logic        reg_rd,
	input wire logic        tx_req,
	input wire logic        ka_no_ack,
	input wire logic        relax_req,
	input wire logic        rx_ka_valid,
	input wire logic [3:0]  rx_ka_tx_sequence,
	input wire logic [3:0]  rx_ka_encoding,
	input wire logic [7:0]  rx_ka_snr,
	input wire logic [7:0]  rx_ka_power,
	// watched outputs
	input wire logic [31:0] reg_rdata,
	input wire logic        tx_ans_valid,
	input wire logic        ka_send,
	input wire logic [3:0]  ka_scheme,
	input wire logic [3:0]  tx_power,
	input wire logic [3:0]  keepalive_tx_sequence,
	input wire logic        ka_failed,
	input wire logic [3:0]  ka_ack_scheme,
	input wire logic [7:0]  last_rx_snr_field,
	input wire logic [7:0]  last_rx_power_field,
	input wire logic [3:0]  last_rx_encoding_field
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	chk_answer_pulse: assert property (1'b1 |=> tx_ans_valid == $past(tx_req))
		else $error("answer strobe does not follow query");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data present without read");
	chk_ka_set: assert property (ka_send |-> ka_scheme <= lrs_pkg::SCH_DBPSK_CC)
		else $error("keep-alive outside allowed schemes");
	chk_retry_same: assert property (ka_no_ack && keepalive_tx_sequence == 4'h0
		|=> ka_send && $stable(ka_scheme) && $stable(tx_power))
		else $error("first retry changed robustness");
	chk_retry_raise: assert property (ka_no_ack && keepalive_tx_sequence >= 4'h1
		&& keepalive_tx_sequence < KA_MAX_RETRY |=> tx_power > $past(tx_power)
		|| ka_scheme < $past(ka_scheme) || ka_scheme == 4'h0)
		else $error("later retry did not raise robustness");
	chk_fail_count: assert property (ka_failed |-> $past(ka_no_ack)
		&& $past(keepalive_tx_sequence) == KA_MAX_RETRY)
		else $error("failure flagged at wrong retry");
	chk_ack_floor: assert property (rx_ka_valid && rx_ka_tx_sequence > 4'h1
		|=> ka_ack_scheme <= $past(rx_ka_encoding))
		else $error("ack less robust than received keep-alive");
	chk_report_copy: assert property (rx_ka_valid |=> last_rx_snr_field == $past(rx_ka_snr)
		&& last_rx_power_field == $past(rx_ka_power)
		&& last_rx_encoding_field == $past(rx_ka_encoding))
		else $error("last keep-alive fields not copied");
	chk_relax_order: assert property (relax_req && ka_scheme < 4'h2
		|=> tx_power == $past(tx_power) && ka_scheme == $past(ka_scheme) + 4'h1)
		else $error("relax touched power before modulation");
endmodule // lrs_sel_chk

bind lrs_selector lrs_sel_chk #(.KA_MAX_RETRY(KA_MAX_RETRY)) u_lrs_sel_chk (.*);

// [testbench/lrs_peer.sv]
// peer node model: acknowledges or drops keep-alive sends
`timescale 1ns/100ps
module lrs_peer (
	// clock
	input  wire logic       mclk,
	// behaviour: 0 prompt ack, 1 slow ack, 2 never acks
	input  wire logic [1:0] mode,
	// keep-alive link
	input  wire logic       ka_send,
	output logic            ka_ack,
	output logic            ka_no_ack
);
	// one process owns the answer lines; they settle at the first edge, inside reset
	int cnt = 0;
	always @(posedge mclk) begin
		ka_ack <= 1'b0;
		ka_no_ack <= 1'b0;
		if (ka_send === 1'b1)
			cnt <= (mode == 2'h1) ? 6 : 1;
		else if (cnt > 0)
			cnt <= cnt - 1;
		// a lost link ack looks like a timeout to the sender
		if (cnt == 1) begin
			ka_ack <= (mode != 2'h2);
			ka_no_ack <= (mode == 2'h2);
		end
	end
endmodule // lrs_peer

// [testbench/test_lrs_selector.sv]
// self-checking bench for the scheme selector
`timescale 1ns/100ps
module test_lrs_selector;
	logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, registration_done = 0;
	logic rx_pkt_valid = 0, rx_pkt_generic = 0, rx_ka_valid = 0, rx_ka_is_request = 0;
	logic tx_req = 0, tx_is_data = 0, tx_frame_b = 0, ka_start = 0, relax_req = 0;
	logic [2:0] rx_peer_id = 0, tx_peer_id = 0, ka_peer_id = 0;
	logic [3:0] rx_capability_field = 0, rx_ka_tx_sequence = 0, rx_ka_encoding = 0;
	logic [7:0] reg_addr = 0, rx_ka_snr = 0, rx_ka_power = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, rd_val;
	logic [1:0] mode = 0;
	logic tx_ans_valid, ka_send, ka_is_response, ka_failed, ka_ack, ka_no_ack;
	logic [3:0] tx_scheme, tx_capability_field, ka_scheme, keepalive_tx_sequence, tx_power;
	logic [3:0] ka_ack_scheme, last_rx_encoding_field;
	logic [7:0] last_rx_snr_field, last_rx_power_field;
	int errors = 0, tests_run = 0, sends, resp, fails;

	lrs_selector #(.AGE_W(2), .TICKS_PER_SEC(10)) u_lrs_selector (.*);
	lrs_peer u_lrs_peer (.*);

	always #2.5 mclk = ~mclk;

	task automatic wrap_up;
		$display("tests_run %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	function automatic logic [3:0] ex(logic [3:0] c, logic b);
		if (c <= lrs_pkg::SCH_LAST_VALID)
			return c;
		return b ? lrs_pkg::MOST_ROBUST_B : lrs_pkg::MOST_ROBUST_A;
	endfunction

	task automatic wr(logic [7:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge mclk);
		reg_wr <= 0;
	endtask

	task automatic rd(logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge mclk);
		reg_rd <= 0;
		@(negedge mclk);
		rd_val = reg_rdata;
		@(posedge mclk);
	endtask

	task automatic q(logic [2:0] p, logic d, logic b, logic [3:0] e);
		tx_peer_id <= p;
		tx_is_data <= d;
		tx_frame_b <= b;
		tx_req <= 1;
		@(posedge mclk);
		tx_req <= 0;
		@(negedge mclk);
		chk("tx_scheme", e, tx_scheme);
		chk("tx_ans_valid", 1, tx_ans_valid);
		@(posedge mclk);
	endtask

	task automatic rx(logic [2:0] p, logic g, logic [3:0] c);
		rx_peer_id <= p;
		rx_pkt_generic <= g;
		rx_capability_field <= c;
		rx_pkt_valid <= 1;
		@(posedge mclk);
		rx_pkt_valid <= 0;
		// let an edge pass so back-to-back reports never reassign the strobe
		@(posedge mclk);
	endtask

	task automatic rxka(logic r, logic [3:0] s, logic [3:0] e);
		rx_ka_valid <= 1;
		rx_ka_is_request <= r;
		rx_ka_tx_sequence <= s;
		rx_ka_encoding <= e;
		rx_ka_snr <= 8'($urandom);
		rx_ka_power <= 8'($urandom);
		@(posedge mclk);
		rx_ka_valid <= 0;
	endtask

	// counts sends, responses and failures over a fixed observation span
	task automatic obs(int n);
		sends = 0;
		resp = 0;
		fails = 0;
		repeat (n) begin
			@(negedge mclk);
			sends += (ka_send === 1'b1);
			resp += (ka_send === 1'b1 && ka_is_response === 1'b1);
			fails += (ka_failed === 1'b1);
		end
		@(posedge mclk);
	endtask

	task automatic ka(logic [1:0] m);
		mode <= m;
		ka_peer_id <= 3'h5;
		ka_start <= 1;
		@(posedge mclk);
		ka_start <= 0;
		obs(40);
		chk("ka_sends", (m == 2'h2) ? 4 : 1, sends);
		chk("ka_fails", (m == 2'h2) ? 1 : 0, fails);
	endtask

	// whole run is near 560 cycles, so 20 us only trips on a hang
	initial begin
		#20000;
		errors++;
		wrap_up;
	end

	initial begin
		logic [2:0] p;
		logic [3:0] c;
		logic b;
		void'($urandom(35));
		repeat (2) @(posedge mclk);
		srst <= 0;
		@(posedge mclk);
		rd(lrs_pkg::OFS_TIMEOUT);
		// the bench runs a two-bit age, so only the low bits of the reset timeout remain
		chk("timeout", 32'(2'(lrs_pkg::TIMEOUT_RST)), rd_val);
		rd(8'h40);
		chk("unmapped", 32'h0, rd_val);
		@(negedge mclk);
		chk("cap_out", lrs_pkg::LOCAL_CAP_RST, tx_capability_field);
		@(posedge mclk);
		wr(lrs_pkg::OFS_LOCAL_CAP, 32'h5);
		rd(lrs_pkg::OFS_LOCAL_CAP);
		chk("local_cap", 32'h5, rd_val);
		chk("cap_out", 4'h5, tx_capability_field);
		$display("test registers done");
		for (int i = 0; i < 4; i++)
			q(3'(i), 1, i[0], ex(4'hf, i[0]));
		q(3'h0, 0, 1, lrs_pkg::CTLSCH_RST);
		$display("test first data done");
		wr(lrs_pkg::OFS_TIMEOUT, 32'h3);
		repeat (40) begin
			p = 3'($urandom);
			c = 4'($urandom % 9);
			b = 1'($urandom);
			if (c == 4'h8)
				c = 4'hf;
			rx(p, 1, c);
			rx(p, 0, ~c);
			q(p, 1, b, ex(c, b));
		end
		repeat (40) @(posedge mclk);
		q(p, 1, 1, lrs_pkg::MOST_ROBUST_B);
		q(p, 1, 0, lrs_pkg::MOST_ROBUST_A);
		repeat (40) @(posedge mclk);
		wr(lrs_pkg::OFS_PEER_SEL, {29'h0, p});
		rd(lrs_pkg::OFS_PEER_SEL);
		chk("age_sat", {1'b1, 25'h0, 2'h3, c}, rd_val & 32'h8000_003f);
		$display("test peer table done");
		ka(2'h0);
		ka(2'h1);
		ka(2'h2);
		chk("power", 4'h2, tx_power);
		q(3'h5, 1, 1, lrs_pkg::SCH_ROBUST_DBPSK);
		wr(lrs_pkg::OFS_POWER, 32'h2);
		ka(2'h2);
		chk("ladder", lrs_pkg::SCH_ROBUST_DBPSK, ka_scheme);
		for (int i = 0; i < 3; i++) begin
			relax_req <= 1;
			@(posedge mclk);
			relax_req <= 0;
			@(negedge mclk);
			chk("ladder", (i < 1) ? 1 : 2, ka_scheme);
			chk("power", (i < 2) ? 2 : 1, tx_power);
			@(posedge mclk);
		end
		$display("test keep-alive send done");
		for (int s = 1; s < 3; s++) begin
			rxka(0, 4'(s), lrs_pkg::SCH_ROBUST_DBPSK);
			@(negedge mclk);
			chk("ack_scheme", (s > 1) ? 0 : lrs_pkg::CTLSCH_RST, ka_ack_scheme);
			@(posedge mclk);
		end
		wr(lrs_pkg::OFS_CTRL, 32'h0000_0203);
		mode <= 2'h0;
		rx_peer_id <= 3'h3;
		rxka(1, 4'h0, lrs_pkg::SCH_DBPSK_CC);
		obs(20);
		chk("response", 1, resp);
		$display("test keep-alive receive done");
		wr(lrs_pkg::OFS_CTRL, 32'h0000_0250);
		registration_done <= 1;
		@(posedge mclk);
		registration_done <= 0;
		q(3'h1, 1, 1, 4'h5);
		wr(lrs_pkg::OFS_CTRL, 32'h0000_0201);
		q(3'h1, 1, 0, 4'h5);
		$display("test fixed scheme done");
		wrap_up;
	end
endmodule // test_lrs_selector
